/* rtl/serial_host_pkg.sv */
// Shared constants, types and state encodings for the serial host port.
// Assumes a 10 MHz core clock; all users reference items as serial_host_pkg::name.
package serial_host_pkg;

  // Data word and buffer geometry
  localparam int WORD_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [BIT_CNT_W-1:0] FIRST_BIT = 3'h0;

  // Request-mode field value that floats the word request pin
  localparam logic [1:0] REQ_MODE_OFF = 2'h0;

  // Core clock rate and derived timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SCK_HALF_NS = 500;
  localparam int I2C_HOLD_NS = 5000;
  localparam int SCK_HALF_CYC_I = (SCK_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int I2C_HOLD_CYC_I = (I2C_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] SCK_HALF_CYC = TMR_W'(SCK_HALF_CYC_I < 1 ? 1 : SCK_HALF_CYC_I);
  localparam logic [TMR_W-1:0] I2C_HOLD_CYC = TMR_W'(I2C_HOLD_CYC_I < 1 ? 1 : I2C_HOLD_CYC_I);
  localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;

  // Static configuration carried as one group
  typedef struct packed {
    logic i2c_sel;
    logic master;
    logic [1:0] req_mode;
  } port_cfg_t;

  // One pad driver: output value and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } pad_drv_t;

  // SPI master sequencer
  typedef enum logic [1:0] {
    SPI_IDLE,
    SPI_WAIT_REQ,
    SPI_CLK_LOW,
    SPI_CLK_HIGH
  } spi_state_t;

  // I2C master start/stop sequencer
  typedef enum logic [2:0] {
    IIC_IDLE,
    IIC_START,
    IIC_HELD,
    IIC_STOP_A,
    IIC_STOP_B
  } iic_state_t;

endpackage

/* rtl/word_buffer.sv */
// Two-entry word buffer with valid/ready on both sides.
// Assumes one clock; the drain side may stall for any time.
`timescale 1ns/10ps
module word_buffer (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Fill side
  input wire logic [serial_host_pkg::WORD_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [serial_host_pkg::WORD_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  logic [serial_host_pkg::WORD_W-1:0] mem_q [serial_host_pkg::BUF_DEPTH];
  logic [serial_host_pkg::WORD_W-1:0] mem_d [serial_host_pkg::BUF_DEPTH];
  logic wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  // Honest full and empty flags
  assign in_ready = (cnt_q != 2'(serial_host_pkg::BUF_DEPTH));
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and occupancy update
  always_comb
  begin
    wr_d = wr_q ^ push;
    rd_d = rd_q ^ pop;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  // Entry storage, one slot per index
  for (genvar i = 0; i < serial_host_pkg::BUF_DEPTH; i++)
  begin : g_slot
    always_comb
    begin
      mem_d[i] = mem_q[i];
      if (push && (int'(wr_q) == i))
        mem_d[i] = in_data;
    end
    always_ff @(posedge mclk)
    begin
      mem_q[i] <= srst ? '0 : mem_d[i];
    end
  end

  // Registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

/* rtl/serial_host_port.sv */
// Serial host port pin logic: SPI master/slave and I2C start/stop on shared pins.
// Assumes srst on mclk; the SPI slave clock arrives on sck_link and may stop between frames.
// Summary of operation
// - SPI master reads the slave-out line; SPI slave drives it.
// - SPI master drives the master-out line; SPI slave samples it.
// - I2C data is sampled when receiving, only pulled low or released when sending.
// - I2C data changes only while the clock line is low, except start/stop.
// - Data falling while clock high is a start; produced and detected.
// - Data rising while clock high is a stop; produced and detected.
// - An idle I2C bus leaves data released and high.
// - Data and both address pins float during every kind of reset.
// - Lower address pin forms an own-address bit in I2C slave only.
// - Upper address pin forms an own-address bit in I2C slave only.
// - SPI slave takes part in transfers only while slave select is low.
// - Slave select low while SPI master sets a bus error flag.
// - Slave select high in slave mode ignores clocks and floats slave-out; each clock still flips the start toggle, releasing word request.
// - Slave drives word request low when ready, releases on the word's first clock.
// - Master waits for a fresh word request assertion before each word.
// - Word request floats in reset and when the request-mode field is zero.
// - Shared pins serve either as SPI or as I2C.
// - SPI master drives the serial clock; slave takes it from outside.
// - I2C master drives the clock open-drain; slave only reads it.
`timescale 1ns/10ps
module serial_host_port (
  // Core clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Serial clock from the external SPI master
  input wire logic sck_link,
  // Configuration and status
  input wire serial_host_pkg::port_cfg_t cfg,
  input wire logic bus_err_clr,
  output logic bus_err,
  output logic [1:0] own_addr_bits,
  // Transmit word stream
  input wire logic [serial_host_pkg::WORD_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Receive word stream
  output logic [serial_host_pkg::WORD_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // I2C bus condition commands and events
  input wire logic iic_start_cmd,
  input wire logic iic_stop_cmd,
  output logic iic_start_seen,
  output logic iic_stop_seen,
  // SPI pins
  input wire logic ss_n_i,
  input wire logic miso_i,
  output serial_host_pkg::pad_drv_t miso_pad,
  input wire logic mosi_i,
  output serial_host_pkg::pad_drv_t mosi_pad,
  output serial_host_pkg::pad_drv_t sck_pad,
  // I2C pins
  input wire logic sda_i,
  output serial_host_pkg::pad_drv_t sda_pad,
  input wire logic scl_i,
  output serial_host_pkg::pad_drv_t scl_pad,
  input wire logic slave_addr_pin_low,
  input wire logic slave_addr_pin_high,
  // Word request pin
  input wire logic word_request_line_n_i,
  output serial_host_pkg::pad_drv_t word_request_line_n_pad
);

  localparam int W = serial_host_pkg::WORD_W;
  localparam int SYN = 8;

  logic spi_mst, spi_slv, iic_mst, iic_slv, req_en;
  logic link_rst_q, link_rst_d, cnt_rst;
  logic [SYN-1:0] sy1_q, sy2_q, sy3_q, sy_in;
  logic ss_n_s, miso_s, sda_s, scl_s, alo_s, ahi_s, wreq_n_s, rxt_s, stt_s;
  logic sda_p, scl_p, wreq_n_p, rxt_p, stt_p;

  // Mode decode
  assign spi_mst = ~cfg.i2c_sel & cfg.master;
  assign spi_slv = ~cfg.i2c_sel & ~cfg.master;
  assign iic_mst = cfg.i2c_sel & cfg.master;
  assign iic_slv = cfg.i2c_sel & ~cfg.master;
  assign req_en = (cfg.req_mode != serial_host_pkg::REQ_MODE_OFF);

  // Link-side registers
  logic [serial_host_pkg::BIT_CNT_W-1:0] lbit_q, lbit_d;
  logic [W-1:0] lrx_q, lrx_d, ltx_q, ltx_d, lword_q, lword_d;
  logic ltog_q, ltog_d, lstart_q, lstart_d;
  logic [W-1:0] tx_hold_q, tx_hold_d;

  // Link domain is held while not SPI slave; bit counter and shifters also while slave select is high
  assign link_rst_d = srst | ~spi_slv;
  assign cnt_rst = link_rst_q | ss_n_i;

  // Slave shift: sample master-out, present next slave-out bit
  always_comb
  begin
    lbit_d = lbit_q + 3'h1;
    lrx_d = {lrx_q[W-2:0], mosi_i};
    ltx_d = {ltx_q[W-2:0], 1'b0};
    if (lbit_q == serial_host_pkg::FIRST_BIT)
      ltx_d = {tx_hold_q[W-2:0], 1'b0};
  end

  // Word and event toggles, survive between frames
  always_comb
  begin
    lword_d = lword_q;
    ltog_d = ltog_q;
    lstart_d = lstart_q;
    if (lbit_q == serial_host_pkg::FIRST_BIT)
      lstart_d = ~lstart_q;
    if (lbit_q == serial_host_pkg::LAST_BIT)
    begin
      lword_d = lrx_d;
      ltog_d = ~ltog_q;
    end
  end

  // Bit counter and shifters, cleared whenever slave select is high
  always_ff @(posedge sck_link or posedge cnt_rst)
  begin
    if (cnt_rst)
    begin
      lbit_q <= serial_host_pkg::FIRST_BIT;
      lrx_q <= '0;
      ltx_q <= '0;
    end
    else
    begin
      lbit_q <= lbit_d;
      lrx_q <= lrx_d;
      ltx_q <= ltx_d;
    end
  end

  // Word hand-off registers
  always_ff @(posedge sck_link or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      lword_q <= '0;
      ltog_q <= 1'b0;
      lstart_q <= 1'b0;
    end
    else
    begin
      lword_q <= lword_d;
      ltog_q <= ltog_d;
      lstart_q <= lstart_d;
    end
  end

  // Pin and toggle synchronisers: two stages, third stage for edge detection
  // Master-out is only ever sampled on the link clock, so it is not synchronised here
  assign sy_in = {ss_n_i, miso_i, sda_i, scl_i, slave_addr_pin_low,
                  slave_addr_pin_high, word_request_line_n_i, ltog_q};
  always_ff @(posedge mclk)
  begin
    sy1_q <= sy_in;
    sy2_q <= sy1_q;
    sy3_q <= sy2_q;
    link_rst_q <= link_rst_d;
  end
  assign {ss_n_s, miso_s, sda_s, scl_s, alo_s, ahi_s, wreq_n_s, rxt_s} = sy2_q;
  assign {sda_p, scl_p, wreq_n_p, rxt_p} = {sy3_q[5], sy3_q[4], sy3_q[1], sy3_q[0]};

  // Start toggle synchroniser
  logic st1_q, st2_q, st3_q;
  always_ff @(posedge mclk)
  begin
    st1_q <= lstart_q;
    st2_q <= st1_q;
    st3_q <= st2_q;
  end
  assign stt_s = st2_q;
  assign stt_p = st3_q;

  // Core-side state
  serial_host_pkg::spi_state_t sst_q, sst_d;
  serial_host_pkg::iic_state_t ist_q, ist_d;
  logic [serial_host_pkg::TMR_W-1:0] stmr_q, stmr_d, itmr_q, itmr_d;
  logic [serial_host_pkg::BIT_CNT_W-1:0] mbit_q, mbit_d;
  logic [W-1:0] msh_q, msh_d, mrx_q, mrx_d;
  logic sck_q, sck_d, fresh_q, fresh_d, err_q, err_d, wreq_q, wreq_d;
  logic sda_pull_q, sda_pull_d, scl_pull_q, scl_pull_d;
  logic iic_st_q, iic_st_d, iic_sp_q, iic_sp_d;
  logic [1:0] addr_q, addr_d;
  logic buf_ready, push, slv_push, mst_done, take_tx;
  logic [W-1:0] push_data;

  // Words into the receive buffer; ready back-pressures the sources
  assign slv_push = spi_slv & (rxt_s != rxt_p);
  assign push = slv_push | mst_done;
  assign push_data = slv_push ? lword_q : mrx_q;
  assign take_tx = tx_valid & tx_ready;
  assign tx_ready = spi_mst ? ((sst_q == serial_host_pkg::SPI_IDLE) & buf_ready)
                            : (spi_slv & ss_n_s);

  // SPI master sequencer and slave transmit hold
  always_comb
  begin
    sst_d = sst_q;
    stmr_d = stmr_q;
    mbit_d = mbit_q;
    msh_d = msh_q;
    mrx_d = mrx_q;
    sck_d = 1'b0;
    mst_done = 1'b0;
    tx_hold_d = tx_hold_q;
    fresh_d = fresh_q | (~wreq_n_s & wreq_n_p);
    if (spi_slv && take_tx)
      tx_hold_d = tx_data;
    unique case (sst_q)
      serial_host_pkg::SPI_IDLE:
        if (spi_mst && take_tx)
        begin
          msh_d = tx_data;
          mbit_d = serial_host_pkg::FIRST_BIT;
          stmr_d = serial_host_pkg::SCK_HALF_CYC;
          sst_d = req_en ? serial_host_pkg::SPI_WAIT_REQ : serial_host_pkg::SPI_CLK_LOW;
        end
      serial_host_pkg::SPI_WAIT_REQ:
        if (fresh_q)
        begin
          fresh_d = 1'b0;
          sst_d = serial_host_pkg::SPI_CLK_LOW;
        end
      serial_host_pkg::SPI_CLK_LOW:
      begin
        stmr_d = stmr_q - serial_host_pkg::TMR_ONE;
        if (stmr_q == serial_host_pkg::TMR_ONE)
        begin
          stmr_d = serial_host_pkg::SCK_HALF_CYC;
          mrx_d = {mrx_q[W-2:0], miso_s};
          sst_d = serial_host_pkg::SPI_CLK_HIGH;
        end
      end
      serial_host_pkg::SPI_CLK_HIGH:
      begin
        sck_d = 1'b1;
        stmr_d = stmr_q - serial_host_pkg::TMR_ONE;
        if (stmr_q == serial_host_pkg::TMR_ONE)
        begin
          sck_d = 1'b0;
          stmr_d = serial_host_pkg::SCK_HALF_CYC;
          msh_d = {msh_q[W-2:0], 1'b0};
          mbit_d = mbit_q + 3'h1;
          sst_d = serial_host_pkg::SPI_CLK_LOW;
          if (mbit_q == serial_host_pkg::LAST_BIT)
          begin
            mst_done = 1'b1;
            sst_d = serial_host_pkg::SPI_IDLE;
          end
        end
      end
    endcase
    if (!spi_mst)
      sst_d = serial_host_pkg::SPI_IDLE;
  end

  // I2C master start/stop sequencer, open-drain pulls only
  always_comb
  begin
    ist_d = ist_q;
    itmr_d = itmr_q - serial_host_pkg::TMR_ONE;
    sda_pull_d = sda_pull_q;
    scl_pull_d = scl_pull_q;
    unique case (ist_q)
      serial_host_pkg::IIC_IDLE:
      begin
        sda_pull_d = 1'b0;
        scl_pull_d = 1'b0;
        if (iic_mst && iic_start_cmd && sda_s && scl_s)
        begin
          sda_pull_d = 1'b1;
          itmr_d = serial_host_pkg::I2C_HOLD_CYC;
          ist_d = serial_host_pkg::IIC_START;
        end
      end
      serial_host_pkg::IIC_START:
        if (itmr_q == serial_host_pkg::TMR_ONE)
        begin
          scl_pull_d = 1'b1;
          ist_d = serial_host_pkg::IIC_HELD;
        end
      serial_host_pkg::IIC_HELD:
        if (iic_stop_cmd)
        begin
          sda_pull_d = 1'b1;
          itmr_d = serial_host_pkg::I2C_HOLD_CYC;
          ist_d = serial_host_pkg::IIC_STOP_A;
        end
      serial_host_pkg::IIC_STOP_A:
        if (itmr_q == serial_host_pkg::TMR_ONE)
        begin
          scl_pull_d = 1'b0;
          itmr_d = serial_host_pkg::I2C_HOLD_CYC;
          ist_d = serial_host_pkg::IIC_STOP_B;
        end
      serial_host_pkg::IIC_STOP_B:
        if (itmr_q == serial_host_pkg::TMR_ONE && scl_s)
        begin
          sda_pull_d = 1'b0;
          ist_d = serial_host_pkg::IIC_IDLE;
        end
      default:
        ist_d = serial_host_pkg::IIC_IDLE;
    endcase
    if (!iic_mst)
      ist_d = serial_host_pkg::IIC_IDLE;
  end

  // Bus conditions, error flag, own address and word request
  always_comb
  begin
    iic_st_d = cfg.i2c_sel & scl_s & scl_p & ~sda_s & sda_p;
    iic_sp_d = cfg.i2c_sel & scl_s & scl_p & sda_s & ~sda_p;
    err_d = (err_q & ~bus_err_clr) | (spi_mst & ~ss_n_s);
    addr_d = iic_slv ? {ahi_s, alo_s} : 2'h0;
    wreq_d = wreq_q;
    if (spi_slv && ss_n_s && buf_ready && tx_valid)
      wreq_d = 1'b1;
    if (!spi_slv || (stt_s != stt_p))
      wreq_d = 1'b0;
  end

  // Core registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sst_q <= serial_host_pkg::SPI_IDLE;
      ist_q <= serial_host_pkg::IIC_IDLE;
      stmr_q <= '0;
      itmr_q <= '0;
      mbit_q <= '0;
      msh_q <= '0;
      mrx_q <= '0;
      sck_q <= 1'b0;
      fresh_q <= 1'b0;
      err_q <= 1'b0;
      wreq_q <= 1'b0;
      sda_pull_q <= 1'b0;
      scl_pull_q <= 1'b0;
      iic_st_q <= 1'b0;
      iic_sp_q <= 1'b0;
      addr_q <= 2'h0;
      tx_hold_q <= '0;
    end
    else
    begin
      sst_q <= sst_d;
      ist_q <= ist_d;
      stmr_q <= stmr_d;
      itmr_q <= itmr_d;
      mbit_q <= mbit_d;
      msh_q <= msh_d;
      mrx_q <= mrx_d;
      sck_q <= sck_d;
      fresh_q <= fresh_d;
      err_q <= err_d;
      wreq_q <= wreq_d;
      sda_pull_q <= sda_pull_d;
      scl_pull_q <= scl_pull_d;
      iic_st_q <= iic_st_d;
      iic_sp_q <= iic_sp_d;
      addr_q <= addr_d;
      tx_hold_q <= tx_hold_d;
    end
  end

  // Receive buffer between both shifters and the user
  word_buffer u_rx_buf (
    .mclk(mclk),
    .srst(srst),
    .in_data(push_data),
    .in_valid(push),
    .in_ready(buf_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // Status outputs
  assign bus_err = err_q;
  assign own_addr_bits = addr_q;
  assign iic_start_seen = iic_st_q;
  assign iic_stop_seen = iic_sp_q;

  // Pad drivers; every enable drops while reset is high
  assign miso_pad.o = (lbit_q == serial_host_pkg::FIRST_BIT) ? tx_hold_q[W-1] : ltx_q[W-1];
  assign miso_pad.oe = spi_slv & ~ss_n_i & ~srst;
  assign mosi_pad.o = msh_q[W-1];
  assign mosi_pad.oe = spi_mst & ~srst;
  assign sck_pad.o = sck_q;
  assign sck_pad.oe = spi_mst & ~srst;
  assign sda_pad.o = 1'b0;
  assign sda_pad.oe = iic_mst & sda_pull_q & ~srst;
  assign scl_pad.o = 1'b0;
  assign scl_pad.oe = iic_mst & scl_pull_q & ~srst;
  assign word_request_line_n_pad.o = ~wreq_q;
  assign word_request_line_n_pad.oe = spi_slv & req_en & ~srst;

endmodule

/* test/serial_host_port_sva.sv */
// Pin rule checker for the serial host port, bound to its top module.
// Assumes cfg only changes while srst is high.
`timescale 1ns/10ps
module serial_host_port_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Configuration, status and pin inputs
  input wire serial_host_pkg::port_cfg_t cfg,
  input wire logic ss_n_i,
  input wire logic sda_i,
  input wire logic scl_i,
  input wire logic slave_addr_pin_low,
  input wire logic slave_addr_pin_high,
  input wire logic bus_err,
  input wire logic [1:0] own_addr_bits,
  input wire logic iic_start_seen,
  input wire logic iic_stop_seen,
  // Pad drivers
  input wire serial_host_pkg::pad_drv_t miso_pad,
  input wire serial_host_pkg::pad_drv_t mosi_pad,
  input wire serial_host_pkg::pad_drv_t sck_pad,
  input wire serial_host_pkg::pad_drv_t sda_pad,
  input wire serial_host_pkg::pad_drv_t scl_pad,
  input wire serial_host_pkg::pad_drv_t word_request_line_n_pad
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Pin direction and float rules
  property p_reset_float;
    disable iff (1'b0) srst |-> !(miso_pad.oe | mosi_pad.oe | sck_pad.oe | sda_pad.oe
      | scl_pad.oe | word_request_line_n_pad.oe);
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("pad driven in reset");
  property p_req_off;
    cfg.req_mode == serial_host_pkg::REQ_MODE_OFF |-> !word_request_line_n_pad.oe;
  endproperty
  a_req_off: assert property (p_req_off) else $error("request pin driven while off");
  property p_miso_float;
    !cfg.i2c_sel && !cfg.master && ss_n_i |-> !miso_pad.oe;
  endproperty
  a_miso_float: assert property (p_miso_float) else $error("slave-out driven unselected");
  property p_miso_master;
    !cfg.i2c_sel && cfg.master |-> !miso_pad.oe;
  endproperty
  a_miso_master: assert property (p_miso_master) else $error("master drives slave-out");
  property p_slave_clocks;
    !cfg.master |-> !sck_pad.oe && !scl_pad.oe && !mosi_pad.oe;
  endproperty
  a_slave_clocks: assert property (p_slave_clocks) else $error("slave drives a clock");
  property p_open_drain;
    sda_pad.oe || scl_pad.oe |-> cfg.i2c_sel && !sda_pad.o && !scl_pad.o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("bad open-drain drive");
  // Status and events
  property p_bus_err;
    (!cfg.i2c_sel && cfg.master && !ss_n_i) [*3] |-> ##[0:2] bus_err;
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus error not flagged");
  property p_addr_slave;
    (cfg.i2c_sel && !cfg.master && $stable({slave_addr_pin_high, slave_addr_pin_low})) [*5]
      |-> own_addr_bits == {slave_addr_pin_high, slave_addr_pin_low};
  endproperty
  a_addr_slave: assert property (p_addr_slave) else $error("address bits wrong");
  property p_start;
    cfg.i2c_sel && $fell(sda_i) && scl_i && $past(scl_i) |-> ##[1:5] iic_start_seen;
  endproperty
  a_start: assert property (p_start) else $error("start not detected");
  property p_stop;
    cfg.i2c_sel && $rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:5] iic_stop_seen;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not detected");
endmodule

bind serial_host_port serial_host_port_sva chk (.mclk, .srst, .cfg, .ss_n_i, .sda_i, .scl_i,
  .slave_addr_pin_low, .slave_addr_pin_high, .bus_err, .own_addr_bits, .iic_start_seen,
  .iic_stop_seen, .miso_pad, .mosi_pad, .sck_pad, .sda_pad, .scl_pad,
  .word_request_line_n_pad);

/* test/spi_far_end.sv */
// Far-end SPI party: slave for master mode, master for slave mode.
// Assumes SPI mode 0 timing; the link clock stands still between frames.
`timescale 1ns/10ps
module spi_far_end (
  // Lines seen at the pins
  input wire logic sck_w,
  input wire logic mosi_w,
  input wire logic miso_w,
  input wire logic wr_w,
  // Lines driven by this end
  output logic sck_m,
  output logic ss_n,
  output logic mosi_m,
  output logic miso_s,
  output logic req_n
);
  logic [7:0] tx_s;
  logic [7:0] rx_s;
  logic wr_mid;
  initial
  begin
    sck_m = 1'b0;
    ss_n = 1'b1;
    mosi_m = 1'b0;
    req_n = 1'b1;
    tx_s = 8'h00;
    rx_s = 8'h00;
    wr_mid = 1'b0;
  end
  // Slave role: sample on rise, shift out MSB first on fall, junk after the word
  always @(posedge sck_w) rx_s <= {rx_s[6:0], mosi_w};
  always @(negedge sck_w) tx_s <= {tx_s[6:0], ~tx_s[0]};
  assign miso_s = tx_s[7];
  // Request pulse towards a master-mode port
  task automatic pulse_req();
    req_n = 1'b0;
    #300;
    req_n = 1'b1;
  endtask
  // Master role: one selected frame, 160 ns clock, then an idle gap with select high
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    ss_n = 1'b0;
    #80;
    for (int i = 7; i >= 0; i--)
    begin
      mosi_m = tx[i];
      #80;
      rx = {rx[6:0], miso_w};
      sck_m = 1'b1;
      #80;
      sck_m = 1'b0;
      if (i == 4)
        wr_mid = wr_w;
    end
    #400;
    ss_n = 1'b1;
    mosi_m = ~mosi_m;
    #800;
  endtask
endmodule

/* test/serial_host_port_tb.sv */
// Self-checking bench for the serial host port.
// Assumes the far-end model and the bound checker are compiled with it.
`timescale 1ns/10ps
module serial_host_port_tb;
  logic mclk, srst, bus_err_clr, tx_valid, rx_ready, iic_start_cmd, iic_stop_cmd;
  logic slave_addr_pin_low, slave_addr_pin_high, sda_pull, scl_pull;
  logic [7:0] tx_data, rx_data, got;
  logic bus_err, tx_ready, rx_valid, iic_start_seen, iic_stop_seen;
  logic [1:0] own_addr_bits;
  serial_host_pkg::port_cfg_t cfg;
  serial_host_pkg::pad_drv_t miso_pad, mosi_pad, sck_pad, sda_pad, scl_pad, wr_pad;
  logic miso_w, mosi_w, sck_w, sda_w, scl_w, wr_w, sck_m, ss_n, mosi_m, miso_s, req_n;
  int errors, num_checks, cycles;
  // Wire resolution; open-drain lines have pull-ups
  assign miso_w = miso_pad.oe ? miso_pad.o : miso_s;
  assign mosi_w = mosi_pad.oe ? mosi_pad.o : mosi_m;
  assign sck_w = sck_pad.oe & sck_pad.o;
  assign sda_w = ~(sda_pad.oe | sda_pull);
  assign scl_w = ~(scl_pad.oe | scl_pull);
  assign wr_w = wr_pad.oe ? wr_pad.o : req_n;
  serial_host_port dut (.mclk, .srst, .sck_link(sck_m), .cfg, .bus_err_clr, .bus_err,
    .own_addr_bits, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready,
    .iic_start_cmd, .iic_stop_cmd, .iic_start_seen, .iic_stop_seen, .ss_n_i(ss_n),
    .miso_i(miso_w), .miso_pad, .mosi_i(mosi_w), .mosi_pad, .sck_pad, .sda_i(sda_w),
    .sda_pad, .scl_i(scl_w), .scl_pad, .slave_addr_pin_low, .slave_addr_pin_high,
    .word_request_line_n_i(wr_w), .word_request_line_n_pad(wr_pad));
  spi_far_end far (.sck_w, .mosi_w, .miso_w, .wr_w, .sck_m, .ss_n, .mosi_m, .miso_s, .req_n);
  // Clock and hang limit
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Reset with a new static mode, pads checked while held
  task automatic set_mode(input serial_host_pkg::port_cfg_t m);
    srst = 1'b1;
    cfg = m;
    repeat (2) @(negedge mclk);
    check("reset oe", {miso_pad.oe, mosi_pad.oe, sck_pad.oe, sda_pad.oe, scl_pad.oe,
      wr_pad.oe}, 8'h00);
    srst = 1'b0;
    @(negedge mclk);
  endtask
  task automatic push(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    for (int n = 0; n < 50 && tx_ready !== 1'b1; n++) @(negedge mclk);
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask
  task automatic master_word(input logic [7:0] d, input logic [7:0] back);
    far.tx_s = back;
    push(d);
    repeat (150) @(negedge mclk);
    check("word before request", tx_ready, 8'h00);
    far.pulse_req();
    for (int n = 0; n < 200 && rx_valid !== 1'b1; n++) @(negedge mclk);
    check("master rx", rx_data, back);
    check("slave got", far.rx_s, d);
  endtask
  task automatic master_words();
    set_mode('{i2c_sel: 1'b0, master: 1'b1, req_mode: 2'h1});
    master_word(8'ha5, 8'h3c);
    master_word(8'h5a, 8'hc3);
    $display("master words done");
  endtask
  task automatic bus_error();
    far.ss_n = 1'b0;
    repeat (6) @(negedge mclk);
    check("bus error", bus_err, 8'h01);
    far.ss_n = 1'b1;
    bus_err_clr = 1'b1;
    repeat (4) @(negedge mclk);
    bus_err_clr = 1'b0;
    check("bus error clear", bus_err, 8'h00);
    $display("bus error done");
  endtask
  task automatic slave_frames();
    set_mode('{i2c_sel: 1'b0, master: 1'b0, req_mode: 2'h1});
    rx_ready = 1'b0;
    tx_data = 8'h96;
    tx_valid = 1'b1;
    for (int n = 0; n < 50 && wr_w !== 1'b0; n++) @(negedge mclk);
    check("request low", wr_w, 8'h00);
    check("unselected oe", miso_pad.oe, 8'h00);
    far.frame(8'h5a, got);
    check("slave tx", got, 8'h96);
    check("request freed", far.wr_mid, 8'h01);
    far.frame(8'h81, got);
    far.frame(8'hff, got);
    repeat (5) @(negedge mclk);
    check("request when full", wr_w, 8'h01);
    tx_valid = 1'b0;
    check("first rx", rx_data, 8'h5a);
    rx_ready = 1'b1;
    @(negedge mclk);
    check("second rx", rx_data, 8'h81);
    @(negedge mclk);
    check("drained", rx_valid, 8'h00);
    $display("slave frames done");
  endtask
  task automatic iic_master();
    {slave_addr_pin_high, slave_addr_pin_low} = 2'h3;
    set_mode('{i2c_sel: 1'b1, master: 1'b1, req_mode: 2'h0});
    iic_start_cmd = 1'b1;
    for (int n = 0; n < 80 && iic_start_seen !== 1'b1; n++) @(negedge mclk);
    iic_start_cmd = 1'b0;
    check("start lines", {sda_w, scl_w}, 8'h01);
    repeat (60) @(negedge mclk);
    check("clock held low", scl_w, 8'h00);
    check("master address", own_addr_bits, 8'h00);
    iic_stop_cmd = 1'b1;
    for (int n = 0; n < 200 && iic_stop_seen !== 1'b1; n++) @(negedge mclk);
    iic_stop_cmd = 1'b0;
    check("stop lines", {sda_w, scl_w}, 8'h03);
    repeat (5) @(negedge mclk);
    check("idle release", sda_pad.oe, 8'h00);
    $display("iic master done");
  endtask
  task automatic iic_slave();
    {slave_addr_pin_high, slave_addr_pin_low} = 2'h2;
    set_mode('{i2c_sel: 1'b1, master: 1'b0, req_mode: 2'h0});
    repeat (6) @(negedge mclk);
    check("slave address", own_addr_bits, 8'h02);
    sda_pull = 1'b1;
    for (int n = 0; n < 10 && iic_start_seen !== 1'b1; n++) @(negedge mclk);
    check("start seen", iic_start_seen, 8'h01);
    sda_pull = 1'b0;
    for (int n = 0; n < 10 && iic_stop_seen !== 1'b1; n++) @(negedge mclk);
    check("stop seen", iic_stop_seen, 8'h01);
    $display("iic slave done");
  endtask
  // Main sequence
  initial
  begin
    {srst, bus_err_clr, tx_valid, iic_start_cmd, iic_stop_cmd, sda_pull, scl_pull} = 7'h40;
    {slave_addr_pin_low, slave_addr_pin_high, rx_ready} = 3'h1;
    tx_data = 8'h00;
    cfg = '{i2c_sel: 1'b0, master: 1'b1, req_mode: 2'h0};
    repeat (2) @(negedge mclk);
    master_words();
    bus_error();
    slave_frames();
    iic_master();
    iic_slave();
    close_out();
  end
endmodule
